// File: mime_entry.sv
// Management-interrupt entry and exit controller of a processor core.
// Assumes the core pipeline reports instruction boundary, retire and store drain
// status on the same clock; only the request pin is asynchronous.
//
// Behaviour
// (RULE_01) Enter management mode only on a pin request or a bus message.
// (RULE_02) Management interrupt cannot be masked by normal interrupt enables.
// (RULE_03) Coinciding NMI, maskable or debug events lose to the management interrupt.
// (RULE_04) No new entry or acknowledge while already in management mode.
// (RULE_05) First request during the mode is latched, served after resume; one only.
// (RULE_06) Waiting for startup interrupt pends requests; entry precedes startup handling.
// (RULE_07) Request may be held off one instruction after shadow instructions.
// (RULE_08) Take at interruptible point after retire and store drain, then save context.
// (RULE_09) Signal entry by acknowledge pin, transaction pulse and status marking.
// (RULE_10) Entry from real, protected or v86 mode; resume returns to that mode.
// (RULE_11) Resume restores context and continues the interrupted program.
// (RULE_12) Resume instruction accepted only inside management mode.
// (RULE_13) Normal operating-system interrupts disabled on entry.
// (RULE_14) Entry disables paging unless the dual-monitor treatment is active.
// (RULE_15) Inside the mode: no privilege, no translation, full 4 GB addressing.
// (RULE_16) Management code runs in the separate management memory space.
// (RULE_17) Default virtualization treatment saves and restores virtualization state.
// (RULE_18) Resume outside management mode raises invalid-opcode.
// (RULE_19) On resume deassert acknowledge, pulse transaction, stop status marking.
// (RULE_20) Base resets to 30000H; handler fetch starts at base plus 8000H.
// (RULE_21) Pending latch clears when its request is taken for entry at a boundary.
// (RULE_22) System logic steers accesses to management memory using the acknowledge.
`timescale 1ns/1ps
module mime_entry
  import mime_pkg::*;
#(
  parameter int SAVE_WORDS = MIME_SAVE_WORDS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Request sources
  input wire logic mgmtRequestPin_n,
  input wire logic busMgmtMessage,
  // Other events at the same boundary
  input wire logic nmiRequest,
  input wire logic intrRequest,
  input wire logic debugRequest,
  // Pipeline status
  input wire logic instrBoundary,
  input wire logic interruptShadow,
  input wire logic allRetired,
  input wire logic storesDrained,
  input wire logic waitForStartup,
  input wire logic startupIntArrive,
  input wire logic [1:0] currentMode,
  input wire logic pagingOn,
  input wire logic dualMonitorActive,
  input wire logic virtActive,
  // Resume instruction
  input wire logic resumeExec,
  input wire logic restoreDone,
  input wire logic [31:0] newBase,
  input wire logic newBaseWrite,
  // Core control outputs
  output logic mgmtMode,
  output logic mgmtAckPin_n,
  output logic mgmtAckTransaction,
  output logic mgmtModeStatusSignal,
  output logic saveWordStrobe,
  output logic [31:0] saveAddress,
  output logic saveVirtState,
  output logic restoreStart,
  output logic restoreVirtState,
  output logic [1:0] returnMode,
  output logic returnPaging,
  output logic handlerFetch,
  output logic [31:0] handlerAddress,
  output logic osIntDisable,
  output logic pagingDisable,
  output logic flatAddressing,
  output logic nmiTaken,
  output logic intrTaken,
  output logic debugTaken,
  output logic startupTaken,
  output logic invalidOpcode
);

  // ==========================================================================
  // Request capture
  logic pinLevel;
  logic pinPrev;
  logic pinEdge;
  logic newRequest;
  logic pendHeld;
  logic pendSet;
  logic pendClear;
  logic startupHeld;
  logic shadowSeen;
  logic canTake;
  mime_state_e state;
  logic [3:0] saveCount;
  logic [31:0] mgmtBase;

  mime_sync pinSync (
    .clock(clock),
    .rst(rst),
    .din(~mgmtRequestPin_n),
    .dout(pinLevel)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      pinPrev <= 1'b0;
    end else begin
      pinPrev <= pinLevel;
    end
  end

  // Edge of the pin so a held-low pin counts as one request
  assign pinEdge = pinLevel & ~pinPrev;
  assign newRequest = pinEdge | busMgmtMessage; // RULE_01 RULE_02

  // Outside the mode a request waits here for a boundary; inside, only the
  // first one is kept, later ones merge into it.
  assign pendSet = newRequest; // RULE_05 RULE_06
  assign pendClear = (state == MIME_IDLE) & canTake; // RULE_21

  mime_pending pendLatch (
    .clock(clock),
    .rst(rst),
    .set(pendSet),
    .clear(pendClear),
    .held(pendHeld)
  );

  // Startup interrupt is remembered while a pended request is served first
  always_ff @(posedge clock) begin
    if (rst) begin
      startupHeld <= 1'b0;
    end else if (startupIntArrive) begin
      startupHeld <= 1'b1;
    end else if (startupTaken) begin
      startupHeld <= 1'b0;
    end
  end

  // Shadow lasts one boundary after the shadow instruction
  always_ff @(posedge clock) begin
    if (rst) begin
      shadowSeen <= 1'b0;
    end else if (instrBoundary) begin
      shadowSeen <= interruptShadow; // RULE_07
    end
  end

  // Waiting for startup masks the request until the startup interrupt shows
  assign canTake = pendHeld & instrBoundary & ~shadowSeen
                 & (~waitForStartup | startupHeld | startupIntArrive); // RULE_06 RULE_08

  // ==========================================================================
  // Entry and exit sequence
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= MIME_IDLE;
    end else begin
      case (state)
        MIME_IDLE: begin
          if (canTake) begin
            state <= MIME_DRAIN; // RULE_04
          end
        end
        MIME_DRAIN: begin
          if (allRetired & storesDrained) begin
            state <= MIME_SAVE; // RULE_08
          end
        end
        MIME_SAVE: begin
          if (saveCount == MIME_SAVE_CNT_ONE) begin
            state <= MIME_HANDLER;
          end
        end
        MIME_HANDLER: begin
          if (resumeExec) begin
            state <= MIME_RESTORE; // RULE_12
          end
        end
        MIME_RESTORE: begin
          if (restoreDone) begin
            state <= MIME_EXIT; // RULE_11
          end
        end
        MIME_EXIT: begin
          state <= MIME_IDLE;
        end
        default: begin
          state <= MIME_IDLE;
        end
      endcase
    end
  end

  // Context save word counter
  always_ff @(posedge clock) begin
    if (rst) begin
      saveCount <= MIME_SAVE_CNT_ZERO;
    end else if (state == MIME_DRAIN) begin
      saveCount <= SAVE_WORDS[3:0];
    end else if (state == MIME_SAVE && saveCount != MIME_SAVE_CNT_ZERO) begin
      saveCount <= saveCount - MIME_SAVE_CNT_ONE;
    end
  end

  // Base can only change inside the mode, as the handler's own doing
  always_ff @(posedge clock) begin
    if (rst) begin
      mgmtBase <= MIME_BASE_RESET; // RULE_20
    end else if (newBaseWrite & (state == MIME_HANDLER)) begin
      mgmtBase <= newBase;
    end
  end

  // ==========================================================================
  // Saved mode and paging
  always_ff @(posedge clock) begin
    if (rst) begin
      returnMode <= MIME_MODE_REAL;
      returnPaging <= 1'b0;
      saveVirtState <= 1'b0;
    end else if (state == MIME_IDLE && canTake) begin
      returnMode <= currentMode; // RULE_10
      returnPaging <= pagingOn;
      saveVirtState <= virtActive & ~dualMonitorActive; // RULE_17
    end
  end

  // ==========================================================================
  // Save stream
  always_ff @(posedge clock) begin
    if (rst) begin
      saveWordStrobe <= 1'b0;
      saveAddress <= 32'h0000_0000;
    end else begin
      saveWordStrobe <= (state == MIME_SAVE) && (saveCount != MIME_SAVE_CNT_ZERO); // RULE_08
      saveAddress <= mgmtBase + MIME_SAVE_OFFSET + {26'h000_0000, saveCount, 2'h0}; // RULE_16
    end
  end

  // ==========================================================================
  // Mode flags and system signalling
  always_ff @(posedge clock) begin
    if (rst) begin
      mgmtMode <= 1'b0;
      mgmtAckPin_n <= 1'b1;
      mgmtModeStatusSignal <= 1'b0;
      osIntDisable <= 1'b0;
      pagingDisable <= 1'b0;
      flatAddressing <= 1'b0;
    end else if (state == MIME_SAVE && saveCount == MIME_SAVE_CNT_ONE) begin
      mgmtMode <= 1'b1;
      mgmtAckPin_n <= 1'b0; // RULE_09 RULE_22
      mgmtModeStatusSignal <= 1'b1;
      osIntDisable <= 1'b1; // RULE_13
      pagingDisable <= ~dualMonitorActive; // RULE_14
      flatAddressing <= 1'b1; // RULE_15
    end else if (state == MIME_EXIT) begin
      mgmtMode <= 1'b0;
      mgmtAckPin_n <= 1'b1; // RULE_19
      mgmtModeStatusSignal <= 1'b0;
      osIntDisable <= 1'b0;
      pagingDisable <= 1'b0;
      flatAddressing <= 1'b0;
    end
  end

  // Acknowledge transaction pulses once on entry and once on exit
  always_ff @(posedge clock) begin
    if (rst) begin
      mgmtAckTransaction <= 1'b0;
    end else begin
      mgmtAckTransaction <= (state == MIME_SAVE && saveCount == MIME_SAVE_CNT_ONE)
                          | (state == MIME_EXIT); // RULE_09 RULE_19
    end
  end

  // Handler fetch at base plus handler offset
  always_ff @(posedge clock) begin
    if (rst) begin
      handlerFetch <= 1'b0;
      handlerAddress <= MIME_BASE_RESET + MIME_HANDLER_OFFSET;
    end else begin
      handlerFetch <= (state == MIME_SAVE && saveCount == MIME_SAVE_CNT_ONE);
      handlerAddress <= mgmtBase + MIME_HANDLER_OFFSET; // RULE_20
    end
  end

  // ==========================================================================
  // Restore and exceptions
  always_ff @(posedge clock) begin
    if (rst) begin
      restoreStart <= 1'b0;
      restoreVirtState <= 1'b0;
      invalidOpcode <= 1'b0;
    end else begin
      restoreStart <= (state == MIME_HANDLER) & resumeExec; // RULE_11
      restoreVirtState <= (state == MIME_HANDLER) & resumeExec & saveVirtState; // RULE_17
      invalidOpcode <= resumeExec & (state != MIME_HANDLER); // RULE_18
    end
  end

  // Other events are taken only when no management request wins the boundary
  always_ff @(posedge clock) begin
    if (rst) begin
      nmiTaken <= 1'b0;
      intrTaken <= 1'b0;
      debugTaken <= 1'b0;
      startupTaken <= 1'b0;
    end else begin
      nmiTaken <= nmiRequest & instrBoundary & ~canTake & (state == MIME_IDLE); // RULE_03
      intrTaken <= intrRequest & instrBoundary & ~canTake & (state == MIME_IDLE); // RULE_03
      debugTaken <= debugRequest & instrBoundary & ~canTake & (state == MIME_IDLE); // RULE_03
      startupTaken <= startupHeld & ~pendHeld & (state == MIME_IDLE) & ~startupTaken; // RULE_06
    end
  end

endmodule

// File: mime_pkg.sv
// Package for the management-interrupt entry block: constants and state codes.
// Assumes a single 200 MHz core clock and a synchronous active-high reset.
package mime_pkg;

  // ==========================================================================
  // Management memory layout
  localparam logic [31:0] MIME_BASE_RESET = 32'h0003_0000;
  localparam logic [31:0] MIME_HANDLER_OFFSET = 32'h0000_8000;
  localparam logic [31:0] MIME_SAVE_OFFSET = 32'h0000_FE00;

  // ==========================================================================
  // Timing
  localparam int MIME_CLOCK_MHZ = 200;
  localparam int MIME_SAVE_WORDS = 8;
  localparam logic [3:0] MIME_SAVE_WORDS_CNT = 4'h8;
  localparam logic [3:0] MIME_SAVE_CNT_ONE = 4'h1;
  localparam logic [3:0] MIME_SAVE_CNT_ZERO = 4'h0;

  // ==========================================================================
  // Operating modes kept across a management visit
  localparam logic [1:0] MIME_MODE_REAL = 2'h0;
  localparam logic [1:0] MIME_MODE_PROT = 2'h1;
  localparam logic [1:0] MIME_MODE_V86 = 2'h2;

  // ==========================================================================
  // Entry and exit sequence
  typedef enum logic [5:0] {
    MIME_IDLE    = 6'b000001,
    MIME_DRAIN   = 6'b000010,
    MIME_SAVE    = 6'b000100,
    MIME_HANDLER = 6'b001000,
    MIME_RESTORE = 6'b010000,
    MIME_EXIT    = 6'b100000
  } mime_state_e;

endpackage

// File: mime_sync.sv
// Two-flop synchroniser for one level arriving from outside the clock domain.
// Assumes the input is a slow level; pulses shorter than one clock may be lost.
`timescale 1ns/1ps
module mime_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Level
  input wire logic din,
  output logic dout
);

  logic stage1;

  always_ff @(posedge clock) begin
    if (rst) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule

// File: mime_pending.sv
// Sticky request latch: set wins over clear, holds a single request.
// Assumes set and clear come from the same clock domain.
`timescale 1ns/1ps
module mime_pending (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic set,
  input wire logic clear,
  output logic held
);

  always_ff @(posedge clock) begin
    if (rst) begin
      held <= 1'b0;
    end else if (set) begin
      held <= 1'b1;
    end else if (clear) begin
      held <= 1'b0;
    end
  end

endmodule

// File: mime_entry_assertions.sv
// Checker for the management-interrupt entry controller, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module mime_entry_assertions
  import mime_pkg::*;
#(
  parameter int SAVE_WORDS = MIME_SAVE_WORDS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched inputs
  input wire logic resumeExec,
  input wire logic nmiRequest,
  // Watched outputs
  input wire logic mgmtMode,
  input wire logic mgmtAckPin_n,
  input wire logic mgmtAckTransaction,
  input wire logic mgmtModeStatusSignal,
  input wire logic saveWordStrobe,
  input wire logic restoreStart,
  input wire logic [1:0] returnMode,
  input wire logic handlerFetch,
  input wire logic [31:0] handlerAddress,
  input wire logic osIntDisable,
  input wire logic nmiTaken,
  input wire logic invalidOpcode
);
  import mime_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [7:0] strobeCount;
  // ==========================================================
  // Save words since the last handler start
  always_ff @(posedge clock) begin
    if (rst || handlerFetch) begin
      strobeCount <= 8'h00;
    end else begin
      strobeCount <= strobeCount + {7'h00, saveWordStrobe};
    end
  end
  sequence entryEdge;
    $rose(mgmtMode);
  endsequence
  sequence exitEdge;
    $fell(mgmtMode);
  endsequence
  chk_ack_tracks_mode: assert property (mgmtAckPin_n == !mgmtMode && mgmtModeStatusSignal == mgmtMode)
    else $error("ack out of step with mode");
  chk_entry_signals: assert property (entryEdge |-> mgmtAckTransaction && handlerFetch && $past(saveWordStrobe))
    else $error("entry signals wrong");
  chk_exit_signals: assert property (exitEdge |-> mgmtAckTransaction && !handlerFetch)
    else $error("exit signals wrong");
  chk_no_reentry: assert property (mgmtAckTransaction |-> $changed(mgmtMode))
    else $error("acknowledge without mode change");
  // The last save word still stands in the handler-start cycle, so it is added here
  chk_save_count: assert property (handlerFetch |->
    strobeCount + {7'h00, saveWordStrobe} == 8'(SAVE_WORDS))
    else $error("save word count wrong");
  chk_reset_base: assert property ($fell(rst) |-> handlerAddress == MIME_BASE_RESET + MIME_HANDLER_OFFSET)
    else $error("handler address after reset");
  chk_os_ints_off: assert property (mgmtMode |-> osIntDisable)
    else $error("os interrupts open in mode");
  chk_bad_resume: assert property (resumeExec && !mgmtMode |=> invalidOpcode && !restoreStart)
    else $error("resume outside mode accepted");
  chk_good_resume: assert property (restoreStart |-> $past(resumeExec) && $past(mgmtMode))
    else $error("restore without resume");
  chk_nmi_loses: assert property (nmiTaken |-> $past(nmiRequest) && !$past(mgmtMode))
    else $error("nmi taken wrongly");
  chk_mode_kept: assert property (mgmtMode && $past(mgmtMode) |-> $stable(returnMode))
    else $error("return mode moved in mode");
endmodule
bind mime_entry mime_entry_assertions #(.SAVE_WORDS(SAVE_WORDS)) chk (.clock(clock), .rst(rst),
  .resumeExec(resumeExec), .nmiRequest(nmiRequest), .mgmtMode(mgmtMode), .mgmtAckPin_n(mgmtAckPin_n),
  .mgmtAckTransaction(mgmtAckTransaction), .mgmtModeStatusSignal(mgmtModeStatusSignal),
  .saveWordStrobe(saveWordStrobe), .restoreStart(restoreStart), .returnMode(returnMode),
  .handlerFetch(handlerFetch), .handlerAddress(handlerAddress), .osIntDisable(osIntDisable),
  .nmiTaken(nmiTaken), .invalidOpcode(invalidOpcode));

// File: mime_system_model.sv
// Model of the pipeline and system logic around the entry controller.
// Assumes it drives only just after the rising edge.
`timescale 1ns/1ps
module mime_system_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // From the controller
  input wire logic restoreStart,
  input wire logic mgmtAckPin_n,
  // To the controller
  output logic allRetired,
  output logic storesDrained,
  output logic restoreDone,
  // Memory steering
  output logic mgmtMemSelect
);
  int restoreWait = 0;
  initial begin
    allRetired = 1'b0;
    storesDrained = 1'b0;
    restoreDone = 1'b0;
  end
  // ==========================================================
  // Random pace, so drain and restore are both quick and slow
  always @(posedge clock) begin
    #1;
    allRetired = ($urandom % 3) != 0;
    storesDrained = ($urandom % 2) == 0;
    restoreDone = !rst && restoreWait == 1;
    if (restoreStart === 1'b1) begin
      restoreWait = 1 + ($urandom % 4);
    end else if (restoreWait > 0) begin
      restoreWait--;
    end
  end
  // Accesses go to management memory while acknowledged
  assign mgmtMemSelect = !mgmtAckPin_n;
endmodule

// File: mime_entry_tb.sv
// Bench for the management-interrupt entry controller.
// Assumes the system model answers drain and restore.
`timescale 1ns/1ps
module mime_entry_tb;
  import mime_pkg::*;
  logic clock, rst = 1'b1, pin_n = 1'b1, busMsg = 1'b0, nmi = 1'b0, intr = 1'b0, dbg = 1'b0;
  logic boundary = 1'b0, waitSu = 1'b0, suArrive = 1'b0, paging = 1'b0, virt = 1'b0, resume = 1'b0;
  logic shadow = 1'b0, dual = 1'b0, flat;
  logic [1:0] mode = 2'h0;
  logic allRetired, storesDrained, restoreDone, memSel, mgmtMode, ackPin_n, saveStrobe, saveVirt, restoreStart;
  logic returnPaging, handlerFetch, osOff, pagingOff, nmiTaken, intrTaken, dbgTaken, suTaken, invalid;
  logic [1:0] returnMode;
  logic [31:0] handlerAddress, saveAddress;
  int bad_count = 0, total_checks = 0, entries = 0, strobes = 0, rivals = 0, startups = 0, invalids = 0;
  mime_entry #(.SAVE_WORDS(MIME_SAVE_WORDS)) DUT (.clock(clock), .rst(rst), .mgmtRequestPin_n(pin_n),
    .busMgmtMessage(busMsg), .nmiRequest(nmi), .intrRequest(intr), .debugRequest(dbg), .instrBoundary(boundary),
    .interruptShadow(shadow), .allRetired(allRetired), .storesDrained(storesDrained), .waitForStartup(waitSu),
    .startupIntArrive(suArrive), .currentMode(mode), .pagingOn(paging), .dualMonitorActive(dual),
    .virtActive(virt), .resumeExec(resume), .restoreDone(restoreDone), .newBase(32'h0), .newBaseWrite(1'b0),
    .mgmtMode(mgmtMode), .mgmtAckPin_n(ackPin_n), .mgmtAckTransaction(), .mgmtModeStatusSignal(),
    .saveWordStrobe(saveStrobe), .saveAddress(saveAddress), .saveVirtState(saveVirt), .restoreStart(restoreStart),
    .restoreVirtState(), .returnMode(returnMode), .returnPaging(returnPaging), .handlerFetch(handlerFetch),
    .handlerAddress(handlerAddress), .osIntDisable(osOff), .pagingDisable(pagingOff), .flatAddressing(flat),
    .nmiTaken(nmiTaken), .intrTaken(intrTaken), .debugTaken(dbgTaken), .startupTaken(suTaken),
    .invalidOpcode(invalid));
  mime_system_model partner (.clock(clock), .rst(rst), .restoreStart(restoreStart), .mgmtAckPin_n(ackPin_n),
    .allRetired(allRetired), .storesDrained(storesDrained), .restoreDone(restoreDone), .mgmtMemSelect(memSel));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ==========================================================
  // Random boundaries and event counting
  always @(posedge clock) begin
    entries += handlerFetch;
    strobes += saveStrobe;
    rivals += nmiTaken + intrTaken + dbgTaken;
    startups += suTaken;
    invalids += invalid;
    // Every save word must land inside the state save area of the reset base
    if (saveStrobe === 1'b1) begin
      check(saveAddress - MIME_BASE_RESET - MIME_SAVE_OFFSET < 32'h0000_0200, "save address");
    end
    #1;
    boundary = ($urandom % 4) != 0;
  end
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task check(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      bad_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task request(input bit viaPin);
    if (viaPin) begin
      pin_n = 1'b0;
      tick(3);
      pin_n = 1'b1;
    end else begin
      busMsg = 1'b1;
      tick(1);
      busMsg = 1'b0;
    end
    tick(4);
  endtask
  task waitMode(input logic lvl);
    int n;
    n = 0;
    while (mgmtMode !== lvl && n < 300) begin
      tick(1);
      n++;
    end
    check(mgmtMode === lvl, "mode change missing");
    // One more edge so the counters above have seen the last registered pulses
    tick(1);
  endtask
  task pulseResume;
    resume = 1'b1;
    tick(1);
    resume = 1'b0;
  endtask
  // Two visits, the first with requests during it, the second for the latched one; rivals coincide with the pending request
  task session(input bit viaPin, input bit withRivals);
    int e0, s0, r0;
    logic [1:0] m;
    e0 = entries;
    s0 = strobes;
    r0 = rivals;
    m = 2'($urandom % 3);
    mode = m;
    paging = 1'($urandom);
    virt = 1'($urandom);
    busMsg = !viaPin;
    pin_n = viaPin ? 1'b0 : 1'b1;
    tick(1);
    busMsg = 1'b0;
    if (viaPin) begin
      tick(2);
    end
    // Rivals rise only once the request is latched, so both meet at one boundary
    pin_n = 1'b1;
    {nmi, intr, dbg} = withRivals ? 3'h7 : 3'h0;
    waitMode(1'b1);
    check(entries == e0 + 1 && strobes - s0 == MIME_SAVE_WORDS, "entry or save count");
    check(returnMode === m && returnPaging === paging && saveVirt === virt, "saved context");
    check(pagingOff === 1'b1 && osOff === 1'b1 && memSel === 1'b1 && flat === 1'b1, "mode environment");
    check(handlerAddress === MIME_BASE_RESET + MIME_HANDLER_OFFSET, "handler address");
    request(!viaPin);
    request(viaPin);
    check(entries == e0 + 1 && mgmtMode === 1'b1, "reentered");
    check(rivals == r0, "rival event taken");
    {nmi, intr, dbg} = 3'h0;
    pulseResume();
    waitMode(1'b0);
    waitMode(1'b1);
    check(entries == e0 + 2, "latched request lost");
    pulseResume();
    waitMode(1'b0);
    tick(30);
    check(entries == e0 + 2 && ackPin_n === 1'b1, "more than one latched");
  endtask
  task close_out;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'h68aaf6a8));
    tick(2);
    rst = 1'b0;
    check(handlerAddress === 32'h0003_8000 && ackPin_n === 1'b1, "reset values");
    pulseResume();
    tick(1);
    check(invalids == 1 && mgmtMode === 1'b0, "resume outside mode");
    for (int s = 0; s < 6; s++) begin
      session(s[0], s[1]);
    end
    waitSu = 1'b1;
    request(1'b1);
    tick(20);
    check(mgmtMode === 1'b0, "entered while waiting");
    suArrive = 1'b1;
    tick(1);
    suArrive = 1'b0;
    waitMode(1'b1);
    check(startups == 0, "startup before entry");
    pulseResume();
    waitMode(1'b0);
    tick(10);
    check(startups == 1, "startup lost");
    waitSu = 1'b0;
    nmi = 1'b1;
    tick(20);
    nmi = 1'b0;
    check(rivals > 0, "lone nmi not taken");
    // Shadow on every boundary holds the request off; dual monitor keeps paging
    dual = 1'b1;
    virt = 1'b1;
    shadow = 1'b1;
    tick(20);
    request(1'b0);
    tick(20);
    check(mgmtMode === 1'b0, "entered in shadow");
    shadow = 1'b0;
    waitMode(1'b1);
    check(pagingOff === 1'b0 && flat === 1'b1, "dual monitor paging");
    check(saveVirt === 1'b0, "virt state saved under dual monitor");
    pulseResume();
    waitMode(1'b0);
    close_out();
  end
endmodule
